//--- rtl/sar_adc_conversion_control.sv
`timescale 1ns/1ns
// Functional notes
// - clock from bus, bus/2 or async
// - hardware trigger starts a conversion
// - deep stop needs both low-volt bits
// - control write aborts, restarts in software trigger mode unless off or blocked by deep stop
// - done flag set per completion, read-only
// - with compare, done only if true
// - done cleared by write or result-low read
// - done with enable raises interrupt
// - single mode: one conversion per trigger
// - continuous mode converts repeatedly
// - channel codes decode inputs, references
// - all-ones code powers off, isolates
// - all-ones stop adds no conversion
// - single mode idles after completion
// - linear ten-bit successive approximation
// - results right-justified, ten or eight bits
// - compare less-than or greater-equal
// - trigger select picks software or hardware
// - active flag spans conversion
// - compare enable turns compare on
// - direction bit selects greater-or-equal
module sar_adc_conversion_control #(
   parameter int RESOLUTION = sar_ctrl_pkg::RES_W
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // control/status register port
   input wire logic ccs_wr_i,
   input wire logic [7:0] ccs_wdata_i,
   output logic [7:0] ccs_rdata_o,
   // second control register port
   input wire logic cs2_wr_i,
   input wire logic [7:0] cs2_wdata_i,
   output logic [7:0] cs2_rdata_o,
   // result and compare
   input wire logic result_low_rd_i,
   input wire logic mode_8bit_i,
   input wire logic [RESOLUTION-1:0] compare_value_i,
   output logic [RESOLUTION-1:0] result_o,
   output logic result_valid_o,
   // conversion clock and trigger
   input wire logic [1:0] clk_sel_i,
   input wire logic async_conv_clock_i,
   input wire logic hw_trigger_in_i,
   // power modes
   input wire logic deep_stop_retention_i,
   input wire logic lowvolt_detect_enable_i,
   input wire logic lowvolt_stop_enable_i,
   // analog side
   input wire logic comparator_i,
   output sar_ctrl_pkg::mux_sel_t mux_sel_o,
   output sar_ctrl_pkg::sar_drive_t sar_drive_o,
   // interrupt
   output logic conv_irq_o
);
   import sar_ctrl_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_FINISH
   } conv_state_t;

   typedef struct packed {
      conv_state_t st;
      logic conv_done_flag;
      logic conv_irq_enable;
      logic continuous_enable;
      logic [CH_W-1:0] channel_select;
      logic trigger_select;
      logic compare_enable;
      logic compare_gte_select;
      logic conv_active_flag;
      logic hw_trig_q;
      logic [RESOLUTION-1:0] sar;
      logic [RESOLUTION-1:0] bit_mask;
      logic [RESOLUTION-1:0] result;
      logic result_valid;
      mux_sel_t mux;
      sar_drive_t drive;
      logic irq;
   } ctrl_state_t;

   ctrl_state_t state_r;
   ctrl_state_t state_nxt;
   logic step;
   logic allowed;
   logic hw_edge;
   logic start;
   logic [RESOLUTION-1:0] final_val;
   logic [RESOLUTION-1:0] fmt_val;
   logic cmp_true;

   ////////////////////////////////////////////////////////////////////
   // helpers

   // channel code to mux selection
   function automatic mux_sel_t decode_channel(input logic [CH_W-1:0] code);
      mux_sel_t m;
      m.src = SRC_NONE;
      m.input_idx = 5'h00;
      if (code <= CH_LAST_INPUT) begin
         m.src = SRC_INPUT;
         m.input_idx = code;
      end else if (code == CH_HIGH_REF) begin
         m.src = SRC_HIGH_REF;
      end else if (code == CH_LOW_REF) begin
         m.src = SRC_LOW_REF;
      end
      return m;
   endfunction

   // compare result against value
   function automatic logic compare_hit(input logic [RESOLUTION-1:0] val,
                                        input logic [RESOLUTION-1:0] ref_val,
                                        input logic gte);
      return gte ? (val >= ref_val) : (val < ref_val);
   endfunction

   ////////////////////////////////////////////////////////////////////
   // conversion step source

   sar_step_gen u_step (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .clk_sel_i(clk_sel_i),
      .async_conv_clock_i(async_conv_clock_i),
      .run_i(state_r.st == ST_CONVERT),
      .step_o(step)
   );

   ////////////////////////////////////////////////////////////////////
   // combinational helpers

   // deep stop halts conversion unless both low-volt bits set
   assign allowed = ~deep_stop_retention_i |
                    (lowvolt_detect_enable_i & lowvolt_stop_enable_i);

   // timer overflow edge, only while idle
   assign hw_edge = hw_trigger_in_i & ~state_r.hw_trig_q;
   assign start = state_r.trigger_select & hw_edge & ~state_r.conv_active_flag &
                  (state_r.channel_select != CH_OFF) & allowed;

   // final sar value and right-justified formatting
   assign final_val = comparator_i ? state_r.sar : (state_r.sar & ~state_r.bit_mask);
   assign fmt_val = mode_8bit_i ?
                    {{(RESOLUTION-8){1'b0}}, final_val[RESOLUTION-1 -: 8]} :
                    final_val;
   assign cmp_true = compare_hit(fmt_val, mode_8bit_i ?
                     {{(RESOLUTION-8){1'b0}}, compare_value_i[7:0]} : compare_value_i,
                     state_r.compare_gte_select);

   ////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      state_nxt = state_r;
      state_nxt.hw_trig_q = hw_trigger_in_i;
      state_nxt.drive.step = 1'b0;

      // second control register write
      if (cs2_wr_i) begin
         state_nxt.trigger_select = cs2_wdata_i[CS2_TRIG_BIT];
         state_nxt.compare_enable = cs2_wdata_i[CS2_CMPEN_BIT];
         state_nxt.compare_gte_select = cs2_wdata_i[CS2_GTE_BIT];
      end

      unique case (state_r.st)
         ST_IDLE: begin
            if (start) begin
               state_nxt.st = ST_CONVERT;
            end
         end
         ST_CONVERT: begin
            if (!allowed) begin
               // deep stop abort also ends the active span
               state_nxt.st = ST_IDLE;
               state_nxt.conv_active_flag = 1'b0;
            end else if (step) begin
               // linear sar: keep or drop current trial bit
               state_nxt.drive.step = 1'b1;
               if (state_r.bit_mask[0]) begin
                  state_nxt.st = ST_FINISH;
               end else begin
                  state_nxt.sar = final_val | (state_r.bit_mask >> 1);
                  state_nxt.bit_mask = state_r.bit_mask >> 1;
               end
            end
         end
         ST_FINISH: begin
            state_nxt.conv_active_flag = 1'b0;
            if (!state_r.compare_enable || cmp_true) begin
               state_nxt.conv_done_flag = 1'b1;
               state_nxt.result = fmt_val;
               state_nxt.result_valid = 1'b1;
            end
            if (state_r.continuous_enable &&
                (!state_r.trigger_select || state_r.continuous_enable)) begin
               state_nxt.st = ST_CONVERT;
            end else begin
               state_nxt.st = ST_IDLE;
            end
         end
         default: state_nxt.st = ST_IDLE;
      endcase

      // entering a conversion loads the first trial
      if (state_nxt.st == ST_CONVERT && state_r.st != ST_CONVERT) begin
         state_nxt.conv_active_flag = 1'b1;
         state_nxt.bit_mask = {1'b1, {(RESOLUTION-1){1'b0}}};
         state_nxt.sar = {1'b1, {(RESOLUTION-1){1'b0}}};
      end

      // result low read clears done, completion wins
      if (result_low_rd_i && !(state_r.st == ST_FINISH && state_nxt.conv_done_flag)) begin
         state_nxt.conv_done_flag = 1'b0;
      end

      // control write: abort and maybe restart
      if (ccs_wr_i) begin
         state_nxt.conv_done_flag = 1'b0;
         state_nxt.conv_irq_enable = ccs_wdata_i[CCS_IEN_BIT];
         state_nxt.continuous_enable = ccs_wdata_i[CCS_CONT_BIT];
         state_nxt.channel_select = ccs_wdata_i[CH_W-1:0];
         state_nxt.conv_active_flag = 1'b0;
         state_nxt.st = ST_IDLE;
         if (ccs_wdata_i[CH_W-1:0] != CH_OFF && !state_r.trigger_select && allowed) begin
            state_nxt.st = ST_CONVERT;
            state_nxt.conv_active_flag = 1'b1;
            state_nxt.bit_mask = {1'b1, {(RESOLUTION-1){1'b0}}};
            state_nxt.sar = {1'b1, {(RESOLUTION-1){1'b0}}};
         end
      end

      // all-ones code powers off and isolates; no extra conversion
      if (state_nxt.channel_select == CH_OFF) begin
         state_nxt.st = ST_IDLE;
         state_nxt.conv_active_flag = 1'b0;
      end

      // analog drive follows the next state
      state_nxt.mux = (state_nxt.st == ST_IDLE) ?
                      '{src: SRC_NONE, input_idx: 5'h00} :
                      decode_channel(state_nxt.channel_select);
      state_nxt.drive.power_on = (state_nxt.st != ST_IDLE);
      state_nxt.drive.trial = state_nxt.sar;
      state_nxt.irq = state_nxt.conv_done_flag & state_nxt.conv_irq_enable;
   end

   ////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= '0;
         state_r.st <= ST_IDLE;
         state_r.channel_select <= CCS_RESET[CH_W-1:0];
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // read views; done flag is read-only
   assign ccs_rdata_o = {state_r.conv_done_flag, state_r.conv_irq_enable,
                         state_r.continuous_enable, state_r.channel_select};
   assign cs2_rdata_o = {state_r.conv_active_flag, state_r.trigger_select,
                         state_r.compare_enable, state_r.compare_gte_select, 4'h0};
   assign result_o = state_r.result;
   assign result_valid_o = state_r.result_valid;
   assign mux_sel_o = state_r.mux;
   assign sar_drive_o = state_r.drive;
   assign conv_irq_o = state_r.irq;

endmodule

//--- rtl/sar_ctrl_pkg.sv
package sar_ctrl_pkg;

   // control/status register field positions
   localparam int CCS_DONE_BIT = 7;
   localparam int CCS_IEN_BIT = 6;
   localparam int CCS_CONT_BIT = 5;
   localparam int CH_W = 5;
   localparam int RES_W = 10;

   // second control register field positions
   localparam int CS2_ACTIVE_BIT = 7;
   localparam int CS2_TRIG_BIT = 6;
   localparam int CS2_CMPEN_BIT = 5;
   localparam int CS2_GTE_BIT = 4;

   // channel codes
   localparam logic [4:0] CH_LAST_INPUT = 5'h1B;
   localparam logic [4:0] CH_RESERVED = 5'h1C;
   localparam logic [4:0] CH_HIGH_REF = 5'h1D;
   localparam logic [4:0] CH_LOW_REF = 5'h1E;
   localparam logic [4:0] CH_OFF = 5'h1F;

   // reset values
   localparam logic [7:0] CCS_RESET = 8'h1F;
   localparam logic [7:0] CS2_RESET = 8'h00;

   // conversion clock select
   localparam logic [1:0] CLK_BUS = 2'h0;
   localparam logic [1:0] CLK_BUS_DIV2 = 2'h1;
   localparam logic [1:0] CLK_ALT = 2'h2;
   localparam logic [1:0] CLK_ASYNC = 2'h3;

   // mux source kind driven to the analog side
   typedef enum logic [1:0] {
      SRC_NONE,
      SRC_INPUT,
      SRC_HIGH_REF,
      SRC_LOW_REF
   } mux_src_t;

   typedef struct packed {
      mux_src_t src;
      logic [4:0] input_idx;
   } mux_sel_t;

   // analog core handshake
   typedef struct packed {
      logic power_on;
      logic step;
      logic [RES_W-1:0] trial;
   } sar_drive_t;

endpackage

//--- rtl/sar_step_gen.sv
`timescale 1ns/1ns
module sar_step_gen (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // selection
   input wire logic [1:0] clk_sel_i,
   input wire logic async_conv_clock_i,
   input wire logic run_i,
   // step enable
   output logic step_o
);
   import sar_ctrl_pkg::*;

   typedef struct packed {
      logic div;
      logic async_q1;
      logic async_q2;
      logic async_q3;
      logic step;
   } step_state_t;

   step_state_t state_r;
   step_state_t state_nxt;

   // pick one step source, alternate clock never steps
   always_comb begin
      state_nxt = state_r;
      state_nxt.async_q1 = async_conv_clock_i;
      state_nxt.async_q2 = state_r.async_q1;
      state_nxt.async_q3 = state_r.async_q2;
      state_nxt.div = run_i ? ~state_r.div : 1'b0;
      state_nxt.step = 1'b0;
      if (run_i) begin
         unique case (clk_sel_i)
            CLK_BUS: state_nxt.step = 1'b1;
            CLK_BUS_DIV2: state_nxt.step = state_r.div;
            CLK_ALT: state_nxt.step = 1'b0;
            CLK_ASYNC: state_nxt.step = state_r.async_q2 & ~state_r.async_q3;
         endcase
      end
   end

   // state register
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign step_o = state_r.step;
endmodule

//--- testbench/sar_far_side_model.sv
`timescale 1ns/1ns
module sar_far_side_model (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // analog core side
   input wire logic [9:0] level_i,
   input wire sar_ctrl_pkg::mux_sel_t mux_sel_i,
   input wire sar_ctrl_pkg::sar_drive_t drive_i,
   output logic comparator_o,
   // wakeup timer
   input wire logic timer_en_i,
   input wire logic [7:0] period_i,
   output logic overflow_o
);
   import sar_ctrl_pkg::*;
   logic [9:0] vin;
   logic [7:0] cnt;
   logic junk;
   // level of the selected source
   always_comb begin
      case (mux_sel_i.src)
         SRC_HIGH_REF: vin = 10'h3FF;
         SRC_LOW_REF: vin = 10'h000;
         default: vin = level_i ^ {mux_sel_i.input_idx, mux_sel_i.input_idx};
      endcase
   end
   // unpowered or isolated core answers with a toggling bit
   assign comparator_o = drive_i.power_on && mux_sel_i.src != SRC_NONE ?
      vin >= drive_i.trial : junk;
   // free running period counter, never gated by power mode
   always_ff @(posedge ref_clk_i) begin
      junk <= rst_n_i ? ~junk : 1'b0;
      cnt <= !rst_n_i || !timer_en_i || cnt == period_i - 8'h01 ? 8'h00 : cnt + 8'h01;
      overflow_o <= rst_n_i && timer_en_i && cnt == period_i - 8'h01;
   end
endmodule

//--- testbench/sar_adc_conversion_control_asserts.sv
`timescale 1ns/1ns
module sar_ctrl_asserts (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // watched ports
   input wire logic ccs_wr_i,
   input wire logic [7:0] ccs_wdata_i,
   input wire logic [7:0] ccs_rdata_o,
   input wire logic [7:0] cs2_rdata_o,
   input wire logic result_low_rd_i,
   input wire logic [1:0] clk_sel_i,
   input wire logic deep_stop_retention_i,
   input wire sar_ctrl_pkg::mux_sel_t mux_sel_o,
   input wire sar_ctrl_pkg::sar_drive_t sar_drive_o,
   input wire logic conv_irq_o
);
   import sar_ctrl_pkg::*;
   wire done = ccs_rdata_o[7];
   wire ien = ccs_rdata_o[6];
   wire act = cs2_rdata_o[7];
   wire go = ccs_wr_i && ccs_wdata_i[4:0] != CH_OFF && !deep_stop_retention_i &&
      !cs2_rdata_o[6];
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // expected mux source for a channel code
   function automatic mux_src_t src_of(input logic [4:0] c);
      return c == CH_HIGH_REF ? SRC_HIGH_REF : c == CH_LOW_REF ? SRC_LOW_REF : SRC_INPUT;
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   property p_start; go |=> act && sar_drive_o.power_on; endproperty
   a_start: assert property (p_start) else $error("write did not start");
   property p_mux; go && ccs_wdata_i[4:0] != CH_RESERVED |=>
      mux_sel_o.src == src_of($past(ccs_wdata_i[4:0])) &&
      (mux_sel_o.src != SRC_INPUT || mux_sel_o.input_idx == $past(ccs_wdata_i[4:0])); endproperty
   a_mux: assert property (p_mux) else $error("wrong mux source");
   property p_off; ccs_wr_i && ccs_wdata_i[4:0] == CH_OFF |=>
      !act && !sar_drive_o.power_on && mux_sel_o.src == SRC_NONE; endproperty
   a_off: assert property (p_off) else $error("off code left core running");
   property p_clear; ccs_wr_i |=> !done; endproperty
   a_clear: assert property (p_clear) else $error("write left done set");
   property p_rd_clear; result_low_rd_i && !act |=> !done; endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read left done set");
   property p_irq_rise; $rose(done) && ien |-> ##[0:1] conv_irq_o; endproperty
   a_irq_rise: assert property (p_irq_rise) else $error("no interrupt on done");
   property p_irq_level; (done && ien) [*2] |-> conv_irq_o; endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level lost");
   property p_single; go && !ccs_wdata_i[5] && clk_sel_i == CLK_BUS ##1 !ccs_wr_i [*8] |->
      ##[2:6] !act && !sar_drive_o.power_on; endproperty
   a_single: assert property (p_single) else $error("single did not idle");
   // main scenarios
   c_cont: cover property (ccs_wr_i && ccs_wdata_i[5]);
   c_irq: cover property ($rose(conv_irq_o));
   c_end: cover property ($fell(act) && done);
endmodule
bind sar_adc_conversion_control sar_ctrl_asserts u_chk (.ref_clk_i, .rst_n_i, .ccs_wr_i,
   .ccs_wdata_i, .ccs_rdata_o, .cs2_rdata_o, .result_low_rd_i, .clk_sel_i,
   .deep_stop_retention_i, .mux_sel_o, .sar_drive_o, .conv_irq_o);

//--- testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sar_ctrl_pkg::*;
   logic ref_clk_i = '0, rst_n_i = '0, ccs_wr_i = '0, cs2_wr_i = '0, result_low_rd_i = '0;
   logic mode_8bit_i = '0, async_conv_clock_i = '0, timer_en = '0, done_q = '0, free_run = '0;
   logic deep_stop_retention_i = '0, lowvolt_detect_enable_i = '0, lowvolt_stop_enable_i = '0;
   logic hw_trigger_in_i, comparator_i, result_valid_o, conv_irq_o;
   logic [1:0] clk_sel_i = '0;
   logic [7:0] ccs_wdata_i = '0, cs2_wdata_i = '0, ccs_rdata_o, cs2_rdata_o, period = 8'h14;
   logic [9:0] compare_value_i = '0, result_o, level = '0, r;
   logic [4:0] codes[5] = '{5'h00, 5'h1B, 5'h1D, 5'h1E, 5'h09};
   logic [9:0] notes[$];
   mux_sel_t mux_sel_o;
   sar_drive_t sar_drive_o;
   int fails = 0, samples_checked = 0, cont_seen = 0, n;
   // clocks
   always #5 ref_clk_i = ~ref_clk_i;
   always #7 async_conv_clock_i = ~async_conv_clock_i;
   sar_adc_conversion_control u_dut (.ref_clk_i, .rst_n_i, .ccs_wr_i, .ccs_wdata_i, .ccs_rdata_o,
      .cs2_wr_i, .cs2_wdata_i, .cs2_rdata_o, .result_low_rd_i, .mode_8bit_i, .compare_value_i,
      .result_o, .result_valid_o, .clk_sel_i, .async_conv_clock_i, .hw_trigger_in_i,
      .deep_stop_retention_i, .lowvolt_detect_enable_i, .lowvolt_stop_enable_i, .comparator_i,
      .mux_sel_o, .sar_drive_o, .conv_irq_o);
   sar_far_side_model u_far (.ref_clk_i, .rst_n_i, .level_i(level), .mux_sel_i(mux_sel_o),
      .drive_i(sar_drive_o), .comparator_o(comparator_i), .timer_en_i(timer_en),
      .period_i(period), .overflow_o(hw_trigger_in_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // result expected from the far-side levels
   function automatic logic [9:0] model_val(input logic [4:0] c);
      logic [9:0] v;
      v = c == CH_HIGH_REF ? 10'h3FF : c == CH_LOW_REF ? 10'h000 : level ^ {c, c};
      return mode_8bit_i ? {2'h0, v[9:2]} : v;
   endfunction
   task automatic wr1(input logic [7:0] d);
      @(posedge ref_clk_i);
      #1 ccs_wdata_i = d;
      ccs_wr_i = 1'b1;
      @(posedge ref_clk_i);
      #1 ccs_wr_i = 1'b0;
      chk("ccs", {2'h0, ccs_rdata_o}, {3'h0, d[6:0]});
   endtask
   task automatic wr2(input logic [7:0] d);
      @(posedge ref_clk_i);
      #1 cs2_wdata_i = d;
      cs2_wr_i = 1'b1;
      @(posedge ref_clk_i);
      #1 cs2_wr_i = 1'b0;
      chk("cs2", {2'h0, cs2_rdata_o & 8'h70}, {2'h0, d & 8'h70});
   endtask
   task automatic conv(input logic [7:0] d, input bit exp);
      if (exp) notes.push_back(model_val(d[4:0]));
      wr1(d);
      for (int i = 0; i < 150 && cs2_rdata_o[7] !== 1'b0; i++) begin
         @(posedge ref_clk_i);
         #1;
      end
      repeat (4) @(posedge ref_clk_i);
      #1 chk("left", 10'(notes.size()), 10'h000);
   endtask
   // result monitor: each new done takes the oldest note, then reads the result
   always @(posedge ref_clk_i) begin
      result_low_rd_i <= #1 1'b0;
      if (rst_n_i && ccs_rdata_o[7] === 1'b1 && !done_q) begin
         chk("valid", {9'h000, result_valid_o}, 10'h001);
         chk("irq", {9'h000, conv_irq_o}, {9'h000, ccs_rdata_o[6]});
         if (notes.size() > 0) chk("result", result_o, notes.pop_front());
         else if (free_run) cont_seen++;
         else chk("done", 10'h001, 10'h000);
         result_low_rd_i <= #1 1'b1;
      end
      done_q <= ccs_rdata_o[7] === 1'b1;
   end
   // watchdog
   initial begin
      repeat (6000) @(posedge ref_clk_i);
      fails++;
      tally_and_finish();
   end
   // tests
   initial begin
      void'($urandom(58));
      repeat (16) @(posedge ref_clk_i);
      #1 rst_n_i = 1'b1;
      chk("ccs reset", {2'h0, ccs_rdata_o}, {2'h0, CCS_RESET});
      chk("cs2 reset", {2'h0, cs2_rdata_o}, {2'h0, CS2_RESET});
      chk("irq", {9'h000, conv_irq_o}, 10'h000);
      $display("test reset done");
      level = 10'($urandom);
      codes[4] = 5'($urandom % 28);
      foreach (codes[i]) begin
         mode_8bit_i = i[0];
         conv({1'b1, i[1], 1'b0, codes[i]}, 1'b1);
      end
      mode_8bit_i = 1'b0;
      $display("test channels done");
      for (int k = 0; k < 8; k++) begin
         r = model_val(5'h07);
         compare_value_i = r + 10'(k[2]);
         wr2({2'h0, k[0], k[1], 4'h0});
         conv(8'h07, !k[0] || (k[1] ? r >= compare_value_i : r < compare_value_i));
      end
      wr2(8'h00);
      $display("test compare done");
      notes.push_back(model_val(5'h05));
      wr1(8'h03);
      repeat (3) @(posedge ref_clk_i);
      conv(8'h05, 1'b0);
      for (int k = 0; k < 4; k++) begin
         clk_sel_i = 2'(k);
         conv(8'h04, k != 2);
      end
      conv(8'h1F, 1'b0);
      clk_sel_i = CLK_BUS;
      deep_stop_retention_i = 1'b1;
      for (int k = 0; k < 4; k++) begin
         {lowvolt_stop_enable_i, lowvolt_detect_enable_i} = 2'(k);
         conv(8'h02, k == 3);
      end
      deep_stop_retention_i = 1'b0;
      $display("test modes done");
      wr2(8'h40);
      repeat (3) notes.push_back(model_val(5'h02));
      timer_en = 1'b1;
      repeat (62) @(posedge ref_clk_i);
      #1 timer_en = 1'b0;
      period = 8'h06;
      repeat (20) @(posedge ref_clk_i);
      #1 notes.push_back(model_val(5'h02));
      timer_en = 1'b1;
      repeat (14) @(posedge ref_clk_i);
      #1 timer_en = 1'b0;
      repeat (20) @(posedge ref_clk_i);
      #1 chk("hw left", 10'(notes.size()), 10'h000);
      wr2(8'h00);
      $display("test trigger done");
      free_run = 1'b1;
      wr1(8'h22);
      repeat (60) @(posedge ref_clk_i);
      wr1(8'h1F);
      n = cont_seen;
      repeat (40) @(posedge ref_clk_i);
      #1 chk("runs", {9'h000, n >= 3}, 10'h001);
      chk("after stop", 10'(cont_seen - n), 10'h000);
      $display("test continuous done");
      tally_and_finish();
   end
endmodule
